//--- hw/dio_pkg.sv
// Package for the eight-channel digital I/O block: widths, timing constants and mode codes.
// Assumes a single 125 MHz clock domain.
package dio_pkg;
  localparam int unsigned NUM_CH = 8;
  localparam int unsigned NUM_PULSE_CH = 4;
  localparam int unsigned CLK_HZ = 125000000;
  // Fastest pulse input per channel group
  localparam int unsigned FAST_IN_HZ = 50000;
  localparam int unsigned SLOW_IN_HZ = 1000;
  // Highest pulse output frequency
  localparam int unsigned PULSE_OUT_MAX_HZ = 10000;
  // Shortest half period allowed on the pulse output, rounded up
  localparam int unsigned PULSE_OUT_MIN_HALF = (CLK_HZ + 2 * PULSE_OUT_MAX_HZ - 1) / (2 * PULSE_OUT_MAX_HZ);
  // Rate scale: 0 Hz gives 4 mA, 1 kHz gives 20 mA, value in microamps
  localparam int unsigned RATE_ZERO_UA = 4000;
  localparam int unsigned RATE_SPAN_UA = 16000;
  localparam int unsigned RATE_FULL_HZ = 1000;
  // Indicator blink length on fail-safe entry, in ms
  localparam int unsigned BLINK_MS = 100;
  localparam int unsigned BLINK_CYC = CLK_HZ / 1000 * BLINK_MS;
  // Clocks the switch needs to cross its synchroniser before it is captured
  localparam int unsigned STRAP_SETTLE = 2;
  localparam int unsigned CNT_W = 32;
  localparam int unsigned RATE_W = 16;
  localparam int unsigned TMR_W = 32;

  // Channel modes
  typedef enum logic [1:0]
  {
    MODE_INPUT = 2'h0,
    MODE_OUTPUT = 2'h1,
    MODE_PULSE_IN = 2'h2,
    MODE_PULSE_OUT = 2'h3
  } ch_mode_t;
endpackage

//--- hw/digital_io_pulse_failsafe.sv
// Eight bidirectional digital I/O channels with output fail-safe; pulse count/rate and pulse output on channels 0 to 3 only.
// Assumes the terminals arrive asynchronously, counts are backed by an external non-volatile store
// through the preload/save ports, and the configuration switch is a static level.
`timescale 1ns/100ps
module digital_io_pulse_failsafe
  import dio_pkg::*;
#(
  parameter int unsigned N = NUM_CH
)
(
  // Clock, reset, enable
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  // Configuration switch 6
  input wire logic i_factory_sw,
  // Per-channel configuration
  input wire logic [2*N-1:0] i_mode,
  input wire logic [N-1:0] i_fs_state,
  input wire logic [N*TMR_W-1:0] i_fs_time,
  input wire logic [CNT_W-1:0] i_count_period,
  input wire logic [N*16-1:0] i_pulse_half,
  // Output updates
  input wire logic [N-1:0] i_upd,
  input wire logic [N-1:0] i_upd_val,
  // Non-volatile count preload
  input wire logic i_nv_load,
  input wire logic [N*CNT_W-1:0] i_nv_count,
  // Terminals (open collector)
  input wire logic [N-1:0] i_term,
  output logic [N-1:0] o_term,
  output logic [N-1:0] o_term_oe_n,
  // Status
  output logic [N-1:0] o_in_val,
  output logic [N-1:0] o_led,
  output logic [N-1:0] o_fs_active,
  output logic [N*CNT_W-1:0] o_count,
  output logic [N*RATE_W-1:0] o_rate_ua,
  output logic o_count_save,
  output logic o_factory_default,
  output logic o_radio_en
);

  // ----------------------------------------------------------------
  // Terminal synchronisers and strap capture
  // ----------------------------------------------------------------
  logic [N-1:0] s1_q, s1_d, s2_q, s2_d, prev_q, prev_d;
  logic fact_q, fact_d, sw1_q, sw1_d, sw2_q, sw2_d, strap_done_q, strap_done_d;
  logic [1:0] settle_q, settle_d;
  logic io_en;

  // factory strap capture, taken once after reset release
  always_comb
  begin
    s1_d = i_term;
    s2_d = s1_q;
    prev_d = s2_q;
    sw1_d = i_factory_sw;
    sw2_d = sw1_q;
    // Capturing on the first edge would only see the synchroniser's reset value
    settle_d = (settle_q == 2'(STRAP_SETTLE)) ? settle_q : settle_q + 1'b1;
    strap_done_d = (settle_q == 2'(STRAP_SETTLE));
    fact_d = strap_done_q ? fact_q : sw2_q;
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      s1_q <= '1;
      s2_q <= '1;
      prev_q <= '1;
      sw1_q <= 1'b0;
      sw2_q <= 1'b0;
      fact_q <= 1'b0;
      strap_done_q <= 1'b0;
      settle_q <= '0;
    end
    else if (i_ce)
    begin
      s1_q <= s1_d;
      s2_q <= s2_d;
      prev_q <= prev_d;
      sw1_q <= sw1_d;
      sw2_q <= sw2_d;
      fact_q <= fact_d;
      strap_done_q <= strap_done_d;
      settle_q <= settle_d;
    end
  end

  // switch on keeps radio and I/O off; sampled level, not the capture
  assign io_en = ~sw2_q & strap_done_q;
  assign o_factory_default = fact_q;
  assign o_radio_en = io_en;

  // ----------------------------------------------------------------
  // Per-channel logic
  // ----------------------------------------------------------------
  logic [N-1:0] drive_q, drive_d, fs_q, fs_d, pout_q, pout_d;
  logic [TMR_W-1:0] tmr_q [N], tmr_d [N];
  logic [TMR_W-1:0] blink_q [N], blink_d [N];
  logic [15:0] half_q [N], half_d [N];
  logic [CNT_W-1:0] cnt_q [N], cnt_d [N], win_cnt_q [N], win_cnt_d [N];
  logic [RATE_W-1:0] rate_q [N], rate_d [N];
  logic [CNT_W-1:0] per_q, per_d;
  logic save_q, save_d;
  logic win_end;

  // Shared counting window; one second of edges gives twice the frequency
  assign win_end = (per_q == '0);
  always_comb
  begin
    per_d = win_end ? i_count_period : per_q - 1'b1;
    save_d = win_end;
  end

  always_comb
  begin
    for (int c = 0; c < N; c++)
    begin
      automatic ch_mode_t md = ch_mode_t'(i_mode[2*c +: 2]);
      automatic logic pulse_ok = (c < NUM_PULSE_CH);
      automatic logic chg = s2_q[c] ^ prev_q[c];
      automatic logic [CNT_W+15:0] scaled = '0;
      automatic logic [15:0] hlf = i_pulse_half[16*c +: 16];
      drive_d[c] = drive_q[c];
      fs_d[c] = fs_q[c];
      tmr_d[c] = tmr_q[c];
      blink_d[c] = (blink_q[c] != '0) ? blink_q[c] - 1'b1 : blink_q[c];
      pout_d[c] = pout_q[c];
      half_d[c] = half_q[c];
      cnt_d[c] = cnt_q[c];
      win_cnt_d[c] = win_cnt_q[c];
      rate_d[c] = rate_q[c];
      if (md == MODE_OUTPUT || (md == MODE_PULSE_OUT && pulse_ok))
      begin
        if (i_upd[c])
        begin
          // update reloads timer and clears fail-safe
          drive_d[c] = i_upd_val[c];
          fs_d[c] = 1'b0;
          blink_d[c] = '0;
          tmr_d[c] = i_fs_time[TMR_W*c +: TMR_W];
        end
        else if (!fs_q[c] && tmr_q[c] != '0)
        begin
          tmr_d[c] = tmr_q[c] - 1'b1;
          if (tmr_q[c] == TMR_W'(1))
          begin
            // expiry forces state and starts blink
            fs_d[c] = 1'b1;
            drive_d[c] = i_fs_state[c];
            blink_d[c] = TMR_W'(BLINK_CYC);
          end
        end
      end
      // pulse output toggles at a half period no shorter than the 10 kHz limit
      if (md == MODE_PULSE_OUT && pulse_ok && drive_q[c])
      begin
        if (half_q[c] == '0)
        begin
          pout_d[c] = ~pout_q[c];
          half_d[c] = (hlf < 16'(PULSE_OUT_MIN_HALF)) ? 16'(PULSE_OUT_MIN_HALF) : hlf;
        end
        else
          half_d[c] = half_q[c] - 1'b1;
      end
      else
        pout_d[c] = 1'b0;
      // count input state changes in pulse channels
      if (md == MODE_PULSE_IN && pulse_ok)
      begin
        if (chg)
          cnt_d[c] = cnt_q[c] + 1'b1;
        win_cnt_d[c] = win_end ? CNT_W'(chg) : win_cnt_q[c] + CNT_W'(chg);
        if (win_end)
        begin
          // linear rate, edges over the window taken as twice the frequency
          scaled = (CNT_W+16)'(win_cnt_q[c]) * (CNT_W+16)'(RATE_SPAN_UA / 2 / RATE_FULL_HZ);
          rate_d[c] = RATE_W'(RATE_ZERO_UA) + scaled[RATE_W-1:0];
        end
      end
      // counts restored from the non-volatile copy
      if (i_nv_load)
        cnt_d[c] = i_nv_count[CNT_W*c +: CNT_W];
    end
  end

  always_ff @(posedge i_clk or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      drive_q <= '0;
      fs_q <= '0;
      pout_q <= '0;
      per_q <= '0;
      save_q <= 1'b0;
      for (int c = 0; c < N; c++)
      begin
        tmr_q[c] <= '0;
        blink_q[c] <= '0;
        half_q[c] <= '0;
        cnt_q[c] <= '0;
        win_cnt_q[c] <= '0;
        rate_q[c] <= RATE_W'(RATE_ZERO_UA);
      end
    end
    else if (i_ce)
    begin
      drive_q <= drive_d;
      fs_q <= fs_d;
      pout_q <= pout_d;
      per_q <= per_d;
      save_q <= save_d;
      tmr_q <= tmr_d;
      blink_q <= blink_d;
      half_q <= half_d;
      cnt_q <= cnt_d;
      win_cnt_q <= win_cnt_d;
      rate_q <= rate_d;
    end
  end

  // ----------------------------------------------------------------
  // Pin and indicator outputs
  // ----------------------------------------------------------------
  always_comb
  begin
    for (int c = 0; c < N; c++)
    begin
      automatic ch_mode_t md = ch_mode_t'(i_mode[2*c +: 2]);
      automatic logic on = (md == MODE_PULSE_OUT) ? pout_q[c] : (md == MODE_OUTPUT) & drive_q[c];
      // active output pulls to common; undriven otherwise or when disabled
      o_term[c] = 1'b0;
      o_term_oe_n[c] = ~(on & io_en);
      // input value is active low terminal; reflects output when driven
      o_in_val[c] = ~s2_q[c] & io_en;
      o_led[c] = o_in_val[c] ^ (blink_q[c] != '0);
      o_fs_active[c] = fs_q[c];
      o_count[CNT_W*c +: CNT_W] = cnt_q[c];
      o_rate_ua[RATE_W*c +: RATE_W] = rate_q[c];
    end
  end
  assign o_count_save = save_q;

endmodule

//--- bench/dio_monitor.sv
// Checker for the digital I/O block, bound to its top ports.
// Assumes the bench runs channels 4 and 5 as outputs.
`timescale 1ns/100ps
module dio_monitor
  import dio_pkg::*;
#(
  parameter int unsigned N = NUM_CH
)
(
  // Inputs
  input wire logic i_clk,
  input wire logic i_sys_rst,
  input wire logic i_ce,
  input wire logic [2*N-1:0] i_mode,
  input wire logic [N-1:0] i_fs_state,
  input wire logic [N-1:0] i_upd,
  input wire logic [N-1:0] i_upd_val,
  // Outputs
  input wire logic [N-1:0] o_term,
  input wire logic [N-1:0] o_term_oe_n,
  input wire logic [N-1:0] o_in_val,
  input wire logic [N-1:0] o_led,
  input wire logic [N-1:0] o_fs_active,
  input wire logic o_count_save,
  input wire logic o_factory_default,
  input wire logic o_radio_en
);
  // --------------------------------------------------
  // One clock domain, so one clocking and one reset
  // --------------------------------------------------
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  chk_upd_drive: assert property (
    i_ce && i_upd[4] && i_mode[9:8] == 2'h1 && o_radio_en |=> o_term_oe_n[4] == !$past(i_upd_val[4]))
    else $error("update not driven");
  chk_upd_clears: assert property (
    i_ce && i_upd[4] && i_mode[9:8] == 2'h1 && o_radio_en |=> !o_fs_active[4])
    else $error("fail-safe not left");
  // Open collector never drives high
  chk_term_low: assert property (o_term == '0)
    else $error("terminal driven high");
  chk_in_mirror: assert property ($fell(o_term_oe_n[4]) |-> ##[1:5] o_in_val[4])
    else $error("input misses output");
  chk_fs_on: assert property (
    $rose(o_fs_active[4]) && i_fs_state[4] |-> ##[0:2] (!o_term_oe_n[4] && !o_led[4]))
    else $error("fail-safe on wrong");
  chk_fs_off: assert property (
    $rose(o_fs_active[5]) && !i_fs_state[5] |-> ##[0:2] (o_term_oe_n[5] && o_led[5]))
    else $error("fail-safe off wrong");
  chk_factory_off: assert property (o_factory_default |-> !o_radio_en && o_term_oe_n == '1)
    else $error("io live in factory");
  chk_save_pulse: assert property (o_count_save |=> !o_count_save)
    else $error("save not a pulse");
endmodule
bind digital_io_pulse_failsafe dio_monitor #(.N(N)) mon_u (.i_clk, .i_sys_rst, .i_ce, .i_mode, .i_fs_state,
  .i_upd, .i_upd_val, .o_term, .o_term_oe_n, .o_in_val, .o_led, .o_fs_active, .o_count_save,
  .o_factory_default, .o_radio_en);

//--- bench/field_model.sv
// Field wiring: pull-ups and contacts on the eight terminals.
// Assumes the design only ever pulls a terminal low.
`timescale 1ns/100ps
module field_model
(
  // Design side and bench contacts
  input wire logic [7:0] i_oe_n,
  input wire logic [7:0] i_contact,
  // Resolved level
  output logic [7:0] o_level
);
  // Pull-up wins only when nothing pulls low, so released lines read high
  // wired low
  assign o_level = i_oe_n & ~i_contact;
endmodule

//--- bench/testbench.sv
// Bench for the digital I/O block: ch0 pulse in, ch1 pulse out, ch4 and ch5 outputs, ch6 input.
// Assumes the field model resolves the terminals.
`timescale 1ns/100ps
module testbench
  import dio_pkg::*;
;
  logic i_clk = 1'b0;
  logic i_sys_rst = 1'b1;
  logic i_factory_sw = 1'b0;
  logic i_nv_load = 1'b0;
  logic [15:0] mode = 16'h050E;
  logic ce = 1'b1;
  logic [7:0] i_upd = 8'h00;
  logic [7:0] i_upd_val = 8'h00;
  logic [7:0] contact = 8'h00;
  logic [8*CNT_W-1:0] i_nv_count = '0;
  logic [7:0] term, o_term, o_term_oe_n, o_in_val, o_led, o_fs_active;
  logic [8*CNT_W-1:0] o_count;
  logic [8*RATE_W-1:0] o_rate_ua;
  logic o_count_save, o_factory_default, o_radio_en;
  int error_cnt = 0;
  int checks_done = 0;
  // Fail-safe time 40 cycles on ch4 and ch5, ch4 fails to on
  // far side keeps the fail-safe time well over twice its update spacing
  digital_io_pulse_failsafe dut_u (.i_clk, .i_sys_rst, .i_ce(ce), .i_factory_sw, .i_mode(mode),
    .i_fs_state(8'h10), .i_fs_time({64'h0, 32'h28, 32'h28, 128'h0}), .i_count_period(32'h00003FFF),
    .i_pulse_half({8{16'h186A}}), .i_upd, .i_upd_val, .i_nv_load, .i_nv_count, .i_term(term), .o_term,
    .o_term_oe_n, .o_in_val, .o_led, .o_fs_active, .o_count, .o_rate_ua, .o_count_save,
    .o_factory_default, .o_radio_en);
  field_model fld_u (.i_oe_n(o_term_oe_n), .i_contact(contact), .o_level(term));
  // 125 MHz clock
  initial
  begin
    forever #4 i_clk = ~i_clk;
  end
  // Compare and count
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge i_clk);
  endtask
  // One-cycle update strobe
  task automatic upd(input int ch, input logic val);
    @(negedge i_clk);
    i_upd[ch] = 1'b1;
    i_upd_val[ch] = val;
    @(negedge i_clk);
    i_upd = 8'h00;
  endtask
  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    cyc(4);
    i_sys_rst = 1'b0;
    cyc(4);
    cmp(o_term_oe_n, 32'hFF);
    cmp(o_rate_ua[15:0], 32'hFA0);
    cmp(o_radio_en, 32'h1);
    upd(4, 1'b1);
    cyc(5);
    cmp({o_in_val[4], o_term_oe_n[4]}, 32'h2);
    upd(4, 1'b0);
    upd(5, 1'b1);
    cyc(25);
    cmp(o_fs_active, 32'h0);
    cyc(25);
    cmp(o_fs_active, 32'h30);
    cmp({o_term_oe_n[5:4], o_led[5:4]}, 32'hA);
    upd(4, 1'b0);
    cyc(3);
    cmp({o_fs_active[4], o_term_oe_n[4], o_led[4]}, 32'h2);
    contact[6] = 1'b1;
    cyc(5);
    cmp({o_in_val[6], o_led[6]}, 32'h3);
    contact[6] = 1'b0;
    cyc(5);
    cmp(o_in_val[6], 32'h0);
    // Ten edges, slow enough for the fastest channel, all inside one counting window
    while (!o_count_save)
      cyc(1);
    repeat (10)
    begin
      cyc(1250);
      contact[0] = ~contact[0];
    end
    cyc(5);
    cmp(o_count[31:0], 32'hA);
    // Ten edges are five periods, read against the 16384-clock window as if it were one second
    while (!o_count_save)
      cyc(1);
    cmp(o_rate_ua[15:0], RATE_ZERO_UA + 5 * RATE_SPAN_UA / RATE_FULL_HZ);
    i_nv_count[31:0] = 32'h00001234;
    i_nv_load = 1'b1;
    cyc(1);
    i_nv_load = 1'b0;
    cyc(2);
    cmp(o_count[31:0], 32'h1234);
    // Enable low freezes the count even across an input change
    ce = 1'b0;
    contact[0] = ~contact[0];
    cyc(8);
    cmp(o_count[31:0], 32'h1234);
    ce = 1'b1;
    cyc(5);
    cmp(o_count[31:0], 32'h1235);
    // Pulse output holds low for at least the shortest half period, then releases
    upd(1, 1'b1);
    cyc(1);
    cmp(o_term_oe_n[1], 32'h0);
    cyc(PULSE_OUT_MIN_HALF - 1);
    cmp(o_term_oe_n[1], 32'h0);
    cyc(3);
    cmp(o_term_oe_n[1], 32'h1);
    cyc(4000);
    i_factory_sw = 1'b1;
    mode = 16'h5555;
    i_sys_rst = 1'b1;
    cyc(4);
    i_sys_rst = 1'b0;
    cyc(6);
    cmp({o_factory_default, o_radio_en}, 32'h2);
    upd(4, 1'b1);
    cyc(2);
    cmp(o_term_oe_n, 32'hFF);
    print_verdict();
  end
  // Hang guard, about twice the expected run
  initial
  begin
    #700000;
    error_cnt++;
    print_verdict();
  end
endmodule
